/* File: rof_consts.svh */
// Constants for the radar object filter: reset values and fixed limits.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ROF_CONSTS_SVH
`define ROF_CONSTS_SVH

// ----------------------------------------------------------------------
// Structure
// ----------------------------------------------------------------------
`define ROF_NUM_RAD 6

// ----------------------------------------------------------------------
// Reset values of the held configuration
// ----------------------------------------------------------------------
`define ROF_AMP_MAX_RST 14'h0000
`define ROF_AMP_MIN_RST 14'h0000
`define ROF_FG_RST 16'h012c
`define ROF_BG_RST 16'h3aca
`define ROF_AZI_R_RST 8'hc4
`define ROF_AZI_L_RST 8'h3c
`define ROF_ELV_D_RST 8'hce
`define ROF_ELV_U_RST 8'h32
`define ROF_RAD_EN_RST 6'h00
`define ROF_RAD_DIST_RST 16'h0000

// ----------------------------------------------------------------------
// Least separations checked on the configuration
// ----------------------------------------------------------------------
// Amplitude gap in tenths of a dB (3 dB)
`define ROF_AMP_GAP 15'h001e
// Foreground to background gap in mm
`define ROF_DIST_GAP 17'h00064

`endif

/* File: rof_pkg.sv */
// Types shared by the radar object filter modules.
// Assumes rof_consts.svh is on the include path.
package rof_pkg;
  `include "rof_consts.svh"

  // ----------------------------------------------------------------------
  // Object field types
  // ----------------------------------------------------------------------
  // Distance in mm
  typedef logic [15:0] rof_dist_t;
  // Amplitude in tenths of a dB
  typedef logic [13:0] rof_amp_t;
  // Angle in whole degrees, two's complement
  typedef logic signed [7:0] rof_ang_t;

  // ----------------------------------------------------------------------
  // Amplitude filter mode: bit 0 upper limit, bit 1 lower limit
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ROF_AMP_OFF = 2'h0,
    ROF_AMP_MAX = 2'h1,
    ROF_AMP_MIN = 2'h2,
    ROF_AMP_BOTH = 2'h3
  } rof_amp_mode_e;
endpackage

/* File: rof_radius.sv */
// One collision radius: gathers hits over a scan and shows them after it.
// Assumes objects arrive already filtered, on the same clock as sys_clk.
`timescale 1ns/1ns
`include "rof_consts.svh"

module rof_radius
  import rof_pkg::*;
(
  input logic sys_clk,
  input logic rst_b,
  input logic ce,
  input logic obj_vld,
  input rof_dist_t obj_dist,
  input logic scan_end,
  input logic rad_en,
  input rof_dist_t rad_dist,
  output logic hit
);

  typedef struct packed {
    logic acc;
    logic hit;
  } rof_rad_s;

  rof_rad_s st_ff;
  rof_rad_s nxt_st;
  logic near;

  // ----------------------------------------------------------------------
  // Hit gathering
  // ----------------------------------------------------------------------
  // Last object of a scan still counts, so near joins the latched value
  always_comb begin
    near = obj_vld && rad_en && (obj_dist <= rad_dist); // RL9
    nxt_st = st_ff;
    nxt_st.acc = (scan_end || !rad_en) ? 1'b0 : (st_ff.acc | near);
    if (!rad_en) begin
      nxt_st.hit = 1'b0; // RL10
    end else if (scan_end) begin
      nxt_st.hit = st_ff.acc | near; // RL9
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign hit = st_ff.hit;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  radius_off_a: assert property (ce && !rad_en |=> !hit) // RL10
    else $error("deactivated radius shows a hit");
  radius_hit_a: assert property (ce && scan_end && near |=> hit) // RL9
    else $error("object inside radius not shown");
  radius_miss_a: assert property (ce && scan_end && !st_ff.acc && !near |=> !hit) // RL9
    else $error("radius hit without object inside");
endmodule

/* File: rof_filter.sv */
// Radar object filter stage: amplitude, distance and angle windows,
// followed by six collision radii.
// Assumes objects and configuration come from logic on sys_clk, so no
// synchroniser is placed on them; scan_end marks the end of each scan.
`timescale 1ns/1ns
`include "rof_consts.svh"

// Operation
// [RL1] Amplitude mode: off, upper, lower, both
// [RL2] Each amplitude limit used only when enabled
// [RL3] Lower limit at least 3 dB below upper
// [RL4] Drop objects outside foreground/background distances
// [RL5] Suppression distances kept 100 mm apart
// [RL6] Azimuth window right to left, default 60
// [RL7] Elevation window down to up, default 50
// [RL8] Six radii, each off or distance
// [RL9] Active radius flags objects within its distance
// [RL10] Only passing objects reach radii; off silent
module rof_filter
  import rof_pkg::*;
(
  input logic sys_clk,
  input logic rst_b,
  input logic ce,
  input logic obj_vld,
  input rof_dist_t obj_dist,
  input rof_ang_t obj_azi,
  input rof_ang_t obj_elv,
  input rof_amp_t obj_amp,
  input logic scan_end,
  input logic cfg_load,
  input rof_amp_mode_e cfg_amp_mode,
  input rof_amp_t cfg_amp_max,
  input rof_amp_t cfg_amp_min,
  input rof_dist_t cfg_fg,
  input rof_dist_t cfg_bg,
  input rof_ang_t cfg_azi_r,
  input rof_ang_t cfg_azi_l,
  input rof_ang_t cfg_elv_d,
  input rof_ang_t cfg_elv_u,
  input logic [5:0] cfg_rad_en,
  input rof_dist_t [5:0] cfg_rad_dist,
  output logic pass_vld,
  output rof_dist_t pass_dist,
  output logic rej_vld,
  output logic cfg_err,
  output logic [5:0] rad_hit
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    rof_amp_mode_e amp_mode;
    rof_amp_t amp_max;
    rof_amp_t amp_min;
    rof_dist_t fg;
    rof_dist_t bg;
    rof_ang_t azi_r;
    rof_ang_t azi_l;
    rof_ang_t elv_d;
    rof_ang_t elv_u;
    logic [5:0] rad_en;
    rof_dist_t [5:0] rad_dist;
    logic cfg_err;
    logic s1_vld;
    logic s1_end;
    rof_dist_t s1_dist;
    logic rej_vld;
  } rof_filt_s;

  localparam rof_filt_s ROF_RST = '{
    amp_mode: ROF_AMP_OFF,
    amp_max: `ROF_AMP_MAX_RST,
    amp_min: `ROF_AMP_MIN_RST,
    fg: `ROF_FG_RST,
    bg: `ROF_BG_RST,
    azi_r: `ROF_AZI_R_RST,
    azi_l: `ROF_AZI_L_RST,
    elv_d: `ROF_ELV_D_RST,
    elv_u: `ROF_ELV_U_RST,
    rad_en: `ROF_RAD_EN_RST,
    rad_dist: {`ROF_NUM_RAD{`ROF_RAD_DIST_RST}},
    cfg_err: 1'b0,
    s1_vld: 1'b0,
    s1_end: 1'b0,
    s1_dist: 16'h0000,
    rej_vld: 1'b0
  };

  rof_filt_s st_ff;
  rof_filt_s nxt_st;

  // ----------------------------------------------------------------------
  // Window tests on the incoming object
  // ----------------------------------------------------------------------
  logic amp_ok;
  logic dist_ok;
  logic azi_ok;
  logic elv_ok;
  logic geo_ok;
  logic keep;
  logic amp_gap_bad;
  logic dist_gap_bad;

  // Disabled limits are simply not looked at
  assign amp_ok = (!st_ff.amp_mode[0] || (obj_amp <= st_ff.amp_max)) && // RL1
                  (!st_ff.amp_mode[1] || (obj_amp >= st_ff.amp_min)); // RL2
  // Limits inclusive; a crossed window passes nothing
  assign dist_ok = (obj_dist >= st_ff.fg) && (obj_dist <= st_ff.bg); // RL4
  assign azi_ok = (obj_azi >= st_ff.azi_r) && (obj_azi <= st_ff.azi_l); // RL6
  assign elv_ok = (obj_elv >= st_ff.elv_d) && (obj_elv <= st_ff.elv_u); // RL7
  assign geo_ok = dist_ok && azi_ok && elv_ok;
  assign keep = amp_ok && geo_ok; // RL10

  // Separation checks; the device only reports, it does not correct
  assign amp_gap_bad = (st_ff.amp_mode == ROF_AMP_BOTH) &&
                       (({1'b0, st_ff.amp_min} + `ROF_AMP_GAP) > {1'b0, st_ff.amp_max}); // RL3
  assign dist_gap_bad = ({1'b0, st_ff.bg}) < ({1'b0, st_ff.fg} + `ROF_DIST_GAP); // RL5

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Configuration is taken all at once so a half-written window never acts
  always_comb begin
    nxt_st = st_ff;
    if (cfg_load) begin
      nxt_st.amp_mode = cfg_amp_mode; // RL1
      nxt_st.amp_max = cfg_amp_max; // RL2
      nxt_st.amp_min = cfg_amp_min; // RL2
      nxt_st.fg = cfg_fg; // RL4
      nxt_st.bg = cfg_bg; // RL4
      nxt_st.azi_r = cfg_azi_r; // RL6
      nxt_st.azi_l = cfg_azi_l; // RL6
      nxt_st.elv_d = cfg_elv_d; // RL7
      nxt_st.elv_u = cfg_elv_u; // RL7
      nxt_st.rad_en = cfg_rad_en; // RL8
      nxt_st.rad_dist = cfg_rad_dist; // RL8
    end
    nxt_st.cfg_err = amp_gap_bad || dist_gap_bad ||
                     (st_ff.azi_r >= st_ff.azi_l) || (st_ff.elv_d >= st_ff.elv_u);
    nxt_st.s1_vld = obj_vld && keep; // RL10
    nxt_st.rej_vld = obj_vld && !keep;
    nxt_st.s1_end = scan_end;
    if (obj_vld) begin
      nxt_st.s1_dist = obj_dist;
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= ROF_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pass_vld = st_ff.s1_vld;
  assign pass_dist = st_ff.s1_dist;
  assign rej_vld = st_ff.rej_vld;
  assign cfg_err = st_ff.cfg_err;

  // ----------------------------------------------------------------------
  // Collision radii
  // ----------------------------------------------------------------------
  // Fed from the filtered stage so rejected objects never count
  for (genvar i = 0; i < `ROF_NUM_RAD; i++) begin : g_rad
    rof_radius u_rad (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .ce(ce),
      .obj_vld(st_ff.s1_vld),
      .obj_dist(st_ff.s1_dist),
      .scan_end(st_ff.s1_end),
      .rad_en(st_ff.rad_en[i]),
      .rad_dist(st_ff.rad_dist[i]),
      .hit(rad_hit[i])
    );
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  amp_upper_a: assert property (ce && obj_vld && st_ff.amp_mode[0] && // RL1
      (obj_amp > st_ff.amp_max) |=> !pass_vld && rej_vld)
    else $error("object above upper amplitude passed");
  amp_lower_a: assert property (ce && obj_vld && st_ff.amp_mode[1] && // RL2
      (obj_amp < st_ff.amp_min) |=> !pass_vld && rej_vld)
    else $error("object below lower amplitude passed");
  amp_off_a: assert property (ce && obj_vld && (st_ff.amp_mode == ROF_AMP_OFF) && // RL1
      geo_ok |=> pass_vld)
    else $error("amplitude off still rejects");
  dist_win_a: assert property (ce && obj_vld && // RL4
      ((obj_dist < st_ff.fg) || (obj_dist > st_ff.bg)) |=> !pass_vld)
    else $error("object outside distance window passed");
  azi_win_a: assert property (ce && obj_vld && // RL6
      ((obj_azi < st_ff.azi_r) || (obj_azi > st_ff.azi_l)) |=> !pass_vld)
    else $error("object outside azimuth window passed");
  elv_win_a: assert property (ce && obj_vld && // RL7
      ((obj_elv < st_ff.elv_d) || (obj_elv > st_ff.elv_u)) |=> !pass_vld)
    else $error("object outside elevation window passed");
  pass_data_a: assert property (ce && obj_vld && keep |=> // RL10
      pass_vld && (pass_dist == $past(obj_dist)))
    else $error("kept object not presented");
  amp_gap_a: assert property (ce && amp_gap_bad |=> cfg_err) // RL3
    else $error("amplitude gap violation not flagged");
  dist_gap_a: assert property (ce && dist_gap_bad |=> cfg_err) // RL5
    else $error("distance gap violation not flagged");
  rad_load_a: assert property (ce && cfg_load |=> // RL8
      (st_ff.rad_dist == $past(cfg_rad_dist)) && (st_ff.rad_en == $past(cfg_rad_en)))
    else $error("radius settings not taken");
endmodule

/* File: rof_obj_src.sv */
// Upstream object source model: presents one object per call.
// Assumes the filter samples on the rising edge of sys_clk.
`timescale 1ns/1ns
module rof_obj_src
  import rof_pkg::*;
(
  input logic sys_clk,
  output logic obj_vld,
  output rof_dist_t obj_dist,
  output rof_ang_t obj_azi,
  output rof_ang_t obj_elv,
  output rof_amp_t obj_amp,
  output logic scan_end
);
  // Idle fields at a fixed value until the first object
  initial begin
    {obj_vld, scan_end, obj_dist, obj_azi, obj_elv, obj_amp} = '0;
  end

  // One object for one cycle; fields then flip so stale data is never valid
  task automatic send(input rof_dist_t d, input rof_ang_t az, el, input rof_amp_t am,
                      input logic se);
    @(posedge sys_clk);
    #1;
    {obj_vld, scan_end, obj_dist, obj_azi, obj_elv, obj_amp} = {1'b1, se, d, az, el, am};
    @(posedge sys_clk);
    #1;
    {obj_vld, scan_end, obj_dist, obj_azi, obj_elv, obj_amp} = {2'h0, ~d, ~az, ~el, ~am};
  endtask
endmodule

/* File: radar_object_filter_collision_bench.sv */
// Self-checking bench for the object filter and collision radii.
// Assumes rof_pkg and the upstream model rof_obj_src are compiled first.
`timescale 1ns/1ns
module radar_object_filter_collision_bench
  import rof_pkg::*;
;
  logic sys_clk, rst_b, ce, obj_vld, scan_end, cfg_load, pass_vld, rej_vld, cfg_err;
  rof_dist_t obj_dist, pass_dist, cfg_fg, cfg_bg;
  rof_ang_t obj_azi, obj_elv, cfg_azi_r, cfg_azi_l, cfg_elv_d, cfg_elv_u;
  rof_amp_t obj_amp, cfg_amp_max, cfg_amp_min;
  rof_amp_mode_e cfg_amp_mode;
  logic [5:0] cfg_rad_en, rad_hit;
  rof_dist_t [5:0] cfg_rad_dist;
  int failures = 0;
  int comparisons = 0;

  rof_obj_src rof_obj_src_i (.sys_clk, .obj_vld, .obj_dist, .obj_azi, .obj_elv, .obj_amp,
                             .scan_end);
  rof_filter rof_filter_i (.sys_clk, .rst_b, .ce, .obj_vld, .obj_dist, .obj_azi, .obj_elv,
    .obj_amp, .scan_end, .cfg_load, .cfg_amp_mode, .cfg_amp_max, .cfg_amp_min, .cfg_fg,
    .cfg_bg, .cfg_azi_r, .cfg_azi_l, .cfg_elv_d, .cfg_elv_u, .cfg_rad_en, .cfg_rad_dist,
    .pass_vld, .pass_dist, .rej_vld, .cfg_err, .rad_hit);

  // ----------------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // About 125 cycles expected; twelve times that before giving up
  initial begin
    #6000;
    failures++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  // Object through the model, verdict seen one edge later
  task automatic ob(input rof_dist_t d, input rof_ang_t az, el, input rof_amp_t am,
                    input logic se, p);
    rof_obj_src_i.send(d, az, el, am, se);
    chk("pass_vld", {15'h0000, p}, {15'h0000, pass_vld});
    chk("rej_vld", {15'h0000, ~p}, {15'h0000, rej_vld});
    if (p) chk("pass_dist", d, pass_dist);
  endtask

  // Config strobe, then flag checked two edges after it
  task automatic lc(input rof_amp_mode_e m, input rof_amp_t mx, mn, input rof_dist_t fg, bg,
                    input logic [5:0] en, input logic e);
    @(posedge sys_clk);
    #1;
    cfg_amp_mode = m;
    {cfg_amp_max, cfg_amp_min, cfg_fg, cfg_bg, cfg_rad_en} = {mx, mn, fg, bg, en};
    cfg_load = 1'b1;
    @(posedge sys_clk);
    #1;
    cfg_load = 1'b0;
    @(posedge sys_clk);
    #1;
    chk("cfg_err", {15'h0000, e}, {15'h0000, cfg_err});
  endtask

  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_b, ce, cfg_load, cfg_amp_max, cfg_amp_min, cfg_rad_en} = {3'h2, 34'h0};
    cfg_amp_mode = ROF_AMP_OFF;
    {cfg_fg, cfg_bg} = {16'h012c, 16'h3aca};
    {cfg_azi_r, cfg_azi_l, cfg_elv_d, cfg_elv_u} = {8'hc4, 8'h3c, 8'hce, 8'h32};
    cfg_rad_dist = {16'h1388, 16'h03ea, 16'h03e9, 16'h03e8, 16'h03e7, 16'h03e6};
    repeat (20) @(posedge sys_clk);
    #1;
    chk("rad_hit", 16'h0000, {10'h000, rad_hit});
    rst_b = 1'b1;
    // Reset windows, inclusive bounds on each side
    ob(16'h012c, 8'h00, 8'h00, 14'h0000, 1'b0, 1'b1);
    ob(16'h012b, 8'h00, 8'h00, 14'h0000, 1'b0, 1'b0);
    ob(16'h3aca, 8'h00, 8'h00, 14'h0000, 1'b0, 1'b1);
    ob(16'h3acb, 8'h00, 8'h00, 14'h0000, 1'b0, 1'b0);
    ob(16'h03e8, 8'h3c, 8'hc4, 14'h0000, 1'b0, 1'b0);
    ob(16'h03e8, 8'h3c, 8'hce, 14'h0000, 1'b0, 1'b1);
    ob(16'h03e8, 8'h3d, 8'h00, 14'h0000, 1'b0, 1'b0);
    ob(16'h03e8, 8'hc4, 8'h32, 14'h0000, 1'b0, 1'b1);
    ob(16'h03e8, 8'hc3, 8'h00, 14'h0000, 1'b0, 1'b0);
    ob(16'h03e8, 8'h00, 8'h33, 14'h0000, 1'b0, 1'b0);
    // Every amplitude mode against both sides of each limit
    for (int m = 0; m < 4; m++) begin
      lc(rof_amp_mode_e'(m), 14'h01f4, 14'h00c8, 16'h012c, 16'h3aca, 6'h00, 1'b0);
      ob(16'h03e8, 8'h00, 8'h00, 14'h0064, 1'b0, ~m[1]);
      ob(16'h03e8, 8'h00, 8'h00, 14'h0258, 1'b0, ~m[0]);
      ob(16'h03e8, 8'h00, 8'h00, 14'h01f4, 1'b0, 1'b1);
      ob(16'h03e8, 8'h00, 8'h00, 14'h00c8, 1'b0, 1'b1);
    end
    // Separation flags at their exact boundaries
    lc(ROF_AMP_BOTH, 14'h00e5, 14'h00c8, 16'h012c, 16'h3aca, 6'h00, 1'b1);
    lc(ROF_AMP_BOTH, 14'h00e6, 14'h00c8, 16'h012c, 16'h3aca, 6'h00, 1'b0);
    // Window left at 900..1000 mm so the radius objects below still pass
    lc(ROF_AMP_OFF, 14'h0000, 14'h0000, 16'h0384, 16'h03e7, 6'h00, 1'b1);
    lc(ROF_AMP_OFF, 14'h0000, 14'h0000, 16'h0384, 16'h03e8, 6'h1f, 1'b0);
    // Rejected near object must not hit; radius 5 off; radius 2 exactly on
    ob(16'h0064, 8'h00, 8'h00, 14'h0000, 1'b0, 1'b0);
    ob(16'h03e8, 8'h00, 8'h00, 14'h0000, 1'b1, 1'b1);
    @(posedge sys_clk);
    #1;
    chk("rad_hit", 16'h001c, {10'h000, rad_hit});
    // Next scan holds only a rejected object inside radii 2 to 5
    ob(16'h03e8, 8'h46, 8'h00, 14'h0000, 1'b1, 1'b0);
    @(posedge sys_clk);
    #1;
    chk("rad_hit", 16'h0000, {10'h000, rad_hit});
    // Frozen stage ignores an object and its scan end
    ce = 1'b0;
    rof_obj_src_i.send(16'h03e8, 8'h00, 8'h00, 14'h0000, 1'b1);
    chk("pass_vld", 16'h0000, {15'h0000, pass_vld});
    @(posedge sys_clk);
    #1;
    chk("rad_hit", 16'h0000, {10'h000, rad_hit});
    ce = 1'b1;
    // Hit gathered early in a scan shows at its end
    ob(16'h03e8, 8'h00, 8'h00, 14'h0000, 1'b0, 1'b1);
    ob(16'h0064, 8'h00, 8'h00, 14'h0000, 1'b1, 1'b0);
    @(posedge sys_clk);
    #1;
    chk("rad_hit", 16'h001c, {10'h000, rad_hit});
    // Switching radius 4 off clears only its flag
    lc(ROF_AMP_OFF, 14'h0000, 14'h0000, 16'h0384, 16'h03e8, 6'h0f, 1'b0);
    chk("rad_hit", 16'h000c, {10'h000, rad_hit});
    // Reset in mid-run clears flags and restores the default windows
    rst_b = 1'b0;
    @(posedge sys_clk);
    #1;
    chk("rad_hit", 16'h0000, {10'h000, rad_hit});
    rst_b = 1'b1;
    ob(16'h012c, 8'h00, 8'h00, 14'h0000, 1'b0, 1'b1);
    // Equal angle limits leave a single-angle window and are flagged
    cfg_azi_l = 8'hc4;
    lc(ROF_AMP_OFF, 14'h0000, 14'h0000, 16'h012c, 16'h3aca, 6'h00, 1'b1);
    {cfg_azi_l, cfg_elv_u} = {8'h3c, 8'hce};
    lc(ROF_AMP_OFF, 14'h0000, 14'h0000, 16'h012c, 16'h3aca, 6'h00, 1'b1);
    complete_run();
  end
endmodule
